// ===== core/fbps_pkg.sv
// Contract
// [R1] program or erase to a protected address is refused
// [R2] protected region starts on a 512-byte boundary and runs to 0xffff
// [R3] on leaving reset the working protect register loads from the nonvolatile protection byte
// [R4] cpu writes to the working protect register are ignored
// [R5] debug-port writes to the working protect register are accepted
// [R6] last unprotected address is boundary bits over nine ones
// [R7] protection active only when the protect disable bit is zero
// [R8] redirection needs no-redirect bit zero and partial protection
// [R9] vectors 0xffc0-0xfffd redirect below the boundary; reset vector never
// [R10] secured: unsecured code or debug accesses to flash or ram are blocked
// [R11] during reset the option byte is copied into the working option register; the code loads ff in reset and copies on the first clock after
// [R12] security field 1:0 is unsecured, all other codes secured
// [R13] while secured the on-chip debug module cannot be enabled
// [R14] backdoor enable zero means no key unlock
// [R15] with key access set, key writes are captured and start no command
// [R16] software writes eight key bytes in order, never on adjacent cycles
// [R17] key access cleared with eight matching bytes unsecures until reset
// [R18] key writes accepted only from secure code, never from debug
// [R19] protecting the top block also protects option, protection and key bytes
// [R20] debug blank check on erased flash disengages security until reset
// [R21] nine 8-bit control registers in high page, two reloaded at reset
// [R22] a command to a protected address is discarded, engine returns idle
// [R23] backdoor enable is bit 7 of the option register
package fbps_pkg;
  localparam logic [15:0] FBPS_NONVOLATILE_PROTECTION_BYTE_ADDR = 16'hffbd;
  localparam logic [15:0] FBPS_NONVOLATILE_OPTION_BYTE_ADDR = 16'hffbf;
  localparam logic [15:0] FBPS_KEY_ADDR = 16'hffb0;
  localparam logic [15:0] FBPS_VEC_LO = 16'hffc0;
  localparam logic [15:0] FBPS_VEC_HI = 16'hfffd;
  localparam logic [15:0] FBPS_BLOCK_ONES = 16'h01ff;
  localparam logic [15:0] FBPS_VEC_MASK = 16'h003f;
  localparam int FBPS_KEY_BYTES = 8;
  // high page control registers, offsets from the flash register base
  localparam logic [3:0] FBPS_REG_CFG = 4'h3;
  localparam logic [3:0] FBPS_REG_PROT = 4'h4;
  localparam logic [3:0] FBPS_REG_OPT = 4'h1;
  localparam logic [3:0] FBPS_REG_NUM = 4'h9;
  localparam int FBPS_DIS_BIT = 0;
  localparam int FBPS_KEY_ACCESS_BIT_BIT = 5;
  localparam int FBPS_BACKDOOR_ENABLE_BIT_BIT = 7;
  localparam int FBPS_NORED_BIT = 6;
  localparam logic [1:0] FBPS_SEC_OPEN = 2'h2;
  localparam logic [7:0] FBPS_ERASED = 8'hff;
  typedef enum logic [2:0] {
    FBPS_ST_IDLE = 3'b001,
    FBPS_ST_KEY = 3'b010,
    FBPS_ST_CHECK = 3'b100
  } fbps_key_e;
endpackage

// ===== core/fbps_core.sv
`timescale 1ns/100ps
module fbps_core
  import fbps_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // nonvolatile bytes, stable at reset
  input wire logic [7:0] nonvolatile_protection_byte,
  input wire logic [7:0] nonvolatile_option_byte,
  input wire logic [63:0] backdoor_key_bytes,
  // high page control register port
  input wire logic reg_wr,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_from_debug,
  output logic [7:0] reg_rdata,
  // memory access request
  input wire logic mem_req,
  input wire logic mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic mem_is_secure_mem,
  input wire logic code_in_secure,
  input wire logic from_debug,
  input wire logic vector_fetch,
  input wire logic [7:0] mem_rdata_raw,
  output logic [15:0] phys_addr,
  output logic mem_wr_allow,
  output logic [7:0] mem_rdata,
  // command launch from the flash command engine
  input wire logic cmd_launch,
  input wire logic [15:0] cmd_addr,
  input wire logic cmd_is_blank_check,
  input wire logic blank_ok,
  output logic cmd_allow,
  output logic cmd_discard,
  // status
  output logic secured,
  output logic debug_enable_allow
);
  logic [7:0] working_protect_reg, next_prot;
  logic [7:0] working_option_reg, next_opt;
  logic [7:0] flash_config_reg, next_cfg;
  logic unsecure_flag, next_unsec;
  logic [63:0] key_cap, next_key;
  logic [3:0] key_cnt, next_key_cnt;
  logic key_bad, next_key_bad;
  logic load_pend, next_load_pend;
  fbps_key_e kst, next_kst;

  logic [6:0] protect_boundary_bits;
  logic protect_disable_bit, no_redirect_bit, backdoor_enable_bit, key_access_bit;
  logic [1:0] security_field;
  logic [15:0] last_unprot;
  logic prot_on, redirect_on, key_wr, is_key_addr, mem_block;
  logic cfg_wr, prot_wr;

  assign protect_boundary_bits = working_protect_reg[7:1];
  assign protect_disable_bit = working_protect_reg[FBPS_DIS_BIT];
  assign no_redirect_bit = working_option_reg[FBPS_NORED_BIT];
  assign backdoor_enable_bit = working_option_reg[FBPS_BACKDOOR_ENABLE_BIT_BIT]; // [R23]
  assign key_access_bit = flash_config_reg[FBPS_KEY_ACCESS_BIT_BIT];
  assign security_field = unsecure_flag ? FBPS_SEC_OPEN : working_option_reg[1:0]; // [R17] [R20]
  assign secured = (security_field != FBPS_SEC_OPEN); // [R12]
  assign debug_enable_allow = !secured; // [R13]

  // top block holds option, protection and key bytes, so it is covered too
  assign last_unprot = {protect_boundary_bits, 9'h1ff}; // [R6] [R19]
  assign prot_on = !protect_disable_bit; // [R7]
  // boundary at the bottom block means every address above it is protected [R2]
  assign redirect_on = prot_on && !no_redirect_bit && (last_unprot != FBPS_BLOCK_ONES)
    && (last_unprot != 16'hffff); // [R8]

  ////////////////////////////////////////////////////////////////////////////////
  // address redirection and access gating
  always_comb begin
    phys_addr = mem_addr;
    if (vector_fetch && redirect_on && mem_addr >= FBPS_VEC_LO && mem_addr <= FBPS_VEC_HI) begin
      phys_addr = {last_unprot[15:6], mem_addr[5:0]}; // [R9]
    end
  end
  assign mem_block = secured && mem_is_secure_mem && (!code_in_secure || from_debug); // [R10]
  assign is_key_addr = (mem_addr >= FBPS_KEY_ADDR) && (mem_addr < FBPS_KEY_ADDR + 16'h0008);
  // key writes are swallowed here and never reach the command latch [R15]
  assign key_wr = mem_req && mem_wr && key_access_bit && is_key_addr;
  assign mem_wr_allow = mem_req && mem_wr && !mem_block && !key_wr; // [R10] [R15]
  assign mem_rdata = mem_block ? 8'h00 : mem_rdata_raw; // [R10]

  assign cmd_discard = cmd_launch && !cmd_is_blank_check && prot_on && (cmd_addr > last_unprot); // [R1] [R22]
  assign cmd_allow = cmd_launch && !cmd_discard;

  ////////////////////////////////////////////////////////////////////////////////
  // control registers
  assign cfg_wr = reg_wr && reg_addr == FBPS_REG_CFG;
  assign prot_wr = reg_wr && reg_addr == FBPS_REG_PROT;
  always_comb begin
    next_prot = working_protect_reg;
    next_opt = working_option_reg;
    next_cfg = flash_config_reg;
    next_load_pend = 1'b0;
    if (load_pend) begin
      next_prot = nonvolatile_protection_byte; // [R3] [R21]
      next_opt = nonvolatile_option_byte; // [R11] [R21]
    end else begin
      if (prot_wr && reg_from_debug) begin
        next_prot = reg_wdata; // [R4] [R5]
      end
      if (cfg_wr && !reg_from_debug) begin
        // backdoor can only be armed when enabled [R14]
        next_cfg[FBPS_KEY_ACCESS_BIT_BIT] = reg_wdata[FBPS_KEY_ACCESS_BIT_BIT] && backdoor_enable_bit;
      end
    end
  end
  always_comb begin
    reg_rdata = 8'h00;
    if (reg_addr == FBPS_REG_OPT) begin
      reg_rdata = {working_option_reg[7:2], security_field};
    end else if (reg_addr == FBPS_REG_CFG) begin
      reg_rdata = flash_config_reg;
    end else if (reg_addr == FBPS_REG_PROT) begin
      reg_rdata = working_protect_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // backdoor key sequence
  always_comb begin
    next_kst = kst;
    next_key = key_cap;
    next_key_cnt = key_cnt;
    next_key_bad = key_bad;
    next_unsec = unsecure_flag;
    if (cmd_launch && cmd_is_blank_check && from_debug && blank_ok) begin
      next_unsec = 1'b1; // [R20]
    end
    case (kst)
      FBPS_ST_IDLE: begin
        next_key_cnt = 4'h0;
        next_key_bad = 1'b0;
        if (key_access_bit) begin
          next_kst = FBPS_ST_KEY;
        end
      end
      FBPS_ST_KEY: begin
        if (key_wr) begin
          // debug or unsecured code cannot feed the comparison [R18]
          if (from_debug || !code_in_secure || mem_addr[2:0] != key_cnt[2:0]) begin
            next_key_bad = 1'b1;
          end
          if (key_cnt < 4'h8) begin
            next_key[{key_cnt[2:0], 3'h0} +: 8] = reg_wdata;
            next_key_cnt = key_cnt + 4'h1;
          end
        end
        if (!key_access_bit) begin
          next_kst = FBPS_ST_CHECK;
        end
      end
      FBPS_ST_CHECK: begin
        next_kst = FBPS_ST_IDLE;
        if (backdoor_enable_bit && !key_bad && key_cnt == 4'h8 && key_cap == backdoor_key_bytes) begin
          next_unsec = 1'b1; // [R17] [R14]
        end
      end
      default: next_kst = FBPS_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      working_protect_reg <= 8'hff;
      working_option_reg <= 8'hff;
      flash_config_reg <= 8'h00;
      unsecure_flag <= 1'b0;
      key_cap <= 64'h0;
      key_cnt <= 4'h0;
      key_bad <= 1'b0;
      load_pend <= 1'b1;
      kst <= FBPS_ST_IDLE;
    end else if (clk_en) begin
      working_protect_reg <= next_prot;
      working_option_reg <= next_opt;
      flash_config_reg <= next_cfg;
      unsecure_flag <= next_unsec;
      key_cap <= next_key;
      key_cnt <= next_key_cnt;
      key_bad <= next_key_bad;
      load_pend <= next_load_pend;
      kst <= next_kst;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  // key sequence steps: a key byte fed from the debug port, then the closing compare
  sequence s_key_dbg_write;
    clk_en && kst == FBPS_ST_KEY && key_wr && from_debug;
  endsequence

  sequence s_key_match;
    clk_en && kst == FBPS_ST_CHECK && backdoor_enable_bit && !key_bad && key_cnt == 4'h8;
  endsequence

  property p_cpu_prot_ro;
    @(posedge ref_clk) disable iff (rst)
    (clk_en && !load_pend && prot_wr && !reg_from_debug) |=> $stable(working_protect_reg);
  endproperty
  a_cpu_prot_ro: assert property (p_cpu_prot_ro) // [R4]
    else $error("cpu changed protect register");

  property p_dbg_prot_wr;
    @(posedge ref_clk) disable iff (rst)
    (clk_en && !load_pend && prot_wr && reg_from_debug) |=> working_protect_reg == $past(reg_wdata);
  endproperty
  a_dbg_prot_wr: assert property (p_dbg_prot_wr) // [R5]
    else $error("debug protect write lost");

  property p_reload_opt;
    @(posedge ref_clk) disable iff (rst)
    (clk_en && load_pend) |=> working_option_reg == $past(nonvolatile_option_byte);
  endproperty
  a_reload_opt: assert property (p_reload_opt) // [R11]
    else $error("option reload missing");

  property p_reload_prot;
    @(posedge ref_clk) disable iff (rst)
    (clk_en && load_pend) |=> working_protect_reg == $past(nonvolatile_protection_byte);
  endproperty
  a_reload_prot: assert property (p_reload_prot) // [R3]
    else $error("protect reload missing");

  property p_discard;
    @(posedge ref_clk) disable iff (rst)
    (cmd_launch && !cmd_is_blank_check && !protect_disable_bit && cmd_addr > last_unprot) |-> !cmd_allow;
  endproperty
  a_discard: assert property (p_discard) // [R1]
    else $error("protected command allowed");

  property p_discard_idle;
    @(posedge ref_clk) disable iff (rst)
    cmd_discard |-> !cmd_allow;
  endproperty
  a_discard_idle: assert property (p_discard_idle) // [R22]
    else $error("discarded command still launched");

  // region checked by page number, independent of the ones-fill address
  property p_region;
    @(posedge ref_clk) disable iff (rst)
    (cmd_launch && !cmd_is_blank_check && !protect_disable_bit && cmd_addr[15:9] > protect_boundary_bits)
      |-> cmd_discard;
  endproperty
  a_region: assert property (p_region) // [R2]
    else $error("page above boundary not protected");

  property p_prot_enable;
    @(posedge ref_clk) disable iff (rst)
    protect_disable_bit |-> !cmd_discard;
  endproperty
  a_prot_enable: assert property (p_prot_enable) // [R7]
    else $error("command refused with protection disabled");

  property p_last_unprot;
    @(posedge ref_clk) disable iff (rst)
    1'b1 |-> last_unprot[15:9] == protect_boundary_bits && &last_unprot[8:0];
  endproperty
  a_last_unprot: assert property (p_last_unprot) // [R6]
    else $error("last unprotected address malformed");

  property p_block_rd;
    @(posedge ref_clk) disable iff (rst)
    (secured && mem_is_secure_mem && from_debug) |-> mem_rdata == 8'h00 && !mem_wr_allow;
  endproperty
  a_block_rd: assert property (p_block_rd) // [R10]
    else $error("secure access leaked");

  property p_block_code;
    @(posedge ref_clk) disable iff (rst)
    (secured && mem_is_secure_mem && !code_in_secure) |-> mem_rdata == 8'h00 && !mem_wr_allow;
  endproperty
  a_block_code: assert property (p_block_code) // [R10]
    else $error("unsecured code reached secure memory");

  property p_open_pass;
    @(posedge ref_clk) disable iff (rst)
    !secured |-> mem_rdata == mem_rdata_raw;
  endproperty
  a_open_pass: assert property (p_open_pass) // [R10]
    else $error("read blocked while unsecured");

  property p_reset_vec;
    @(posedge ref_clk) disable iff (rst)
    (mem_addr > FBPS_VEC_HI) |-> phys_addr == mem_addr;
  endproperty
  a_reset_vec: assert property (p_reset_vec) // [R9]
    else $error("reset vector redirected");

  property p_redirect;
    @(posedge ref_clk) disable iff (rst)
    (vector_fetch && redirect_on && mem_addr >= FBPS_VEC_LO && mem_addr <= FBPS_VEC_HI)
      |-> phys_addr <= last_unprot && phys_addr[5:0] == mem_addr[5:0];
  endproperty
  a_redirect: assert property (p_redirect) // [R9]
    else $error("vector not moved below boundary");

  property p_no_redirect;
    @(posedge ref_clk) disable iff (rst)
    (no_redirect_bit || protect_disable_bit) |-> phys_addr == mem_addr;
  endproperty
  a_no_redirect: assert property (p_no_redirect) // [R8]
    else $error("redirect while disabled");

  property p_backdoor_enable_bit;
    @(posedge ref_clk) disable iff (rst)
    (!backdoor_enable_bit && !load_pend) |=> !key_access_bit;
  endproperty
  a_backdoor_enable_bit: assert property (p_backdoor_enable_bit) // [R14]
    else $error("key access without enable");

  property p_dbg_on;
    @(posedge ref_clk) disable iff (rst)
    secured |-> !debug_enable_allow;
  endproperty
  a_dbg_on: assert property (p_dbg_on) // [R13]
    else $error("debug enabled while secured");

  property p_sec_code;
    @(posedge ref_clk) disable iff (rst)
    (!unsecure_flag && working_option_reg[1:0] != FBPS_SEC_OPEN) |-> secured;
  endproperty
  a_sec_code: assert property (p_sec_code) // [R12]
    else $error("secure code reads as open");

  property p_key_no_cmd;
    @(posedge ref_clk) disable iff (rst)
    key_wr |-> !mem_wr_allow;
  endproperty
  a_key_no_cmd: assert property (p_key_no_cmd) // [R15]
    else $error("key write reached the array");

  property p_key_debug;
    @(posedge ref_clk) disable iff (rst)
    s_key_dbg_write |=> key_bad;
  endproperty
  a_key_debug: assert property (p_key_debug) // [R18]
    else $error("debug key byte accepted");

  property p_cfg_debug;
    @(posedge ref_clk) disable iff (rst)
    (clk_en && !load_pend && cfg_wr && reg_from_debug) |=> $stable(flash_config_reg);
  endproperty
  a_cfg_debug: assert property (p_cfg_debug) // [R18]
    else $error("debug armed key access");

  property p_unlock;
    @(posedge ref_clk) disable iff (rst)
    (s_key_match and (key_cap == backdoor_key_bytes)) |=> !secured;
  endproperty
  a_unlock: assert property (p_unlock) // [R17]
    else $error("matching key did not unlock");

  property p_unsec_sticky;
    @(posedge ref_clk) disable iff (rst)
    unsecure_flag |=> unsecure_flag;
  endproperty
  a_unsec_sticky: assert property (p_unsec_sticky) // [R17]
    else $error("unlock lost before reset");

  property p_blank_unsec;
    @(posedge ref_clk) disable iff (rst)
    (clk_en && cmd_launch && cmd_is_blank_check && from_debug && blank_ok) |=> !secured;
  endproperty
  a_blank_unsec: assert property (p_blank_unsec) // [R20]
    else $error("blank check did not unlock");
endmodule

// ===== verification/fbps_flash_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// array contents come from the low address byte only, so a redirected vector fetch reads
// the same as a plain one, and a blocked read (00) matches real data only where the low byte is 5a
module fbps_flash_model (
  input wire logic [15:0] phys_addr,
  output logic [7:0] rdata
);
  assign rdata = phys_addr[7:0] ^ 8'h5a;
endmodule

// ===== verification/flash_block_protect_security_tb.sv
`timescale 1ns/100ps
module flash_block_protect_security_tb;
  import fbps_pkg::*;
  typedef struct {logic [15:0] a; logic [2:0] f; logic [15:0] c, ph; logic [7:0] rd; logic dis;} fbps_row_s;
  localparam logic [63:0] KEY = 64'h0123456789abcdef;
  logic ref_clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_from_debug = 1'h0, mem_req = 1'h0, mem_wr = 1'h0;
  logic mem_is_secure_mem = 1'h1, code_in_secure = 1'h1, from_debug = 1'h0, vector_fetch = 1'h0;
  logic cmd_launch = 1'h0, cmd_is_blank_check = 1'h0, blank_ok = 1'h0;
  logic [7:0] nvp = 8'hff, nvo = 8'hff, reg_wdata = 8'h00, raw, reg_rdata, mem_rdata;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] mem_addr = 16'h0000, cmd_addr = 16'h0000, phys_addr;
  logic mem_wr_allow, cmd_allow, cmd_discard, secured, debug_enable_allow;
  int err_total = 0, samples_checked = 0, cyc = 0;
  // vector fetch, secure code, debug flags packed as {vf, cs, dbg}
  fbps_row_s rows[5] = '{'{16'hffc0, 3'h6, 16'hf9ff, 16'hf9c0, 8'h9a, 1'h0},
                         '{16'hfffd, 3'h6, 16'hfa00, 16'hf9fd, 8'ha7, 1'h1},
                         '{16'hfffe, 3'h6, 16'hffff, 16'hfffe, 8'ha4, 1'h1},
                         '{16'hffc0, 3'h0, 16'h0000, 16'hffc0, 8'h00, 1'h0},
                         '{16'h1234, 3'h3, 16'hffb0, 16'h1234, 8'h00, 1'h1}};
  ////////////////////////////////////////////////////////////////////////////////
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      end_of_test();
    end
  end
  fbps_core DUT (.ref_clk(ref_clk), .rst(rst), .clk_en(1'h1), .nonvolatile_protection_byte(nvp),
    .nonvolatile_option_byte(nvo), .backdoor_key_bytes(KEY), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_from_debug(reg_from_debug), .reg_rdata(reg_rdata), .mem_req(mem_req),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_is_secure_mem(mem_is_secure_mem),
    .code_in_secure(code_in_secure), .from_debug(from_debug), .vector_fetch(vector_fetch),
    .mem_rdata_raw(raw), .phys_addr(phys_addr), .mem_wr_allow(mem_wr_allow), .mem_rdata(mem_rdata),
    .cmd_launch(cmd_launch), .cmd_addr(cmd_addr), .cmd_is_blank_check(cmd_is_blank_check),
    .blank_ok(blank_ok), .cmd_allow(cmd_allow), .cmd_discard(cmd_discard), .secured(secured),
    .debug_enable_allow(debug_enable_allow));
  fbps_flash_model u_mem (.phys_addr(phys_addr), .rdata(raw));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic do_reset(input logic [7:0] p, input logic [7:0] o);
    nvp = p;
    nvo = o;
    rst = 1'h1;
    repeat (5) @(negedge ref_clk);
    rst = 1'h0;
    // first rising edge loads the nonvolatile copies, requests start after the second falling edge
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d, input logic dbg);
    reg_addr = a;
    reg_wdata = d;
    reg_from_debug = dbg;
    reg_wr = 1'h1;
    @(negedge ref_clk);
    reg_wr = 1'h0;
    @(negedge ref_clk);
  endtask
  task automatic key_try(input logic dbg, input logic armed);
    wreg(FBPS_REG_CFG, 8'h20, 1'h0);
    from_debug = dbg;
    mem_wr = 1'h1;
    for (int i = 0; i < 8; i++) begin
      mem_addr = FBPS_KEY_ADDR + 16'(i);
      reg_wdata = KEY[8*i+:8];
      mem_req = 1'h1;
      #1 chk(16'(mem_wr_allow), 16'(!armed));
      @(negedge ref_clk);
      mem_req = 1'h0;
      // an idle cycle between key writes, never adjacent bus cycles
      @(negedge ref_clk);
    end
    mem_wr = 1'h0;
    from_debug = 1'h0;
    wreg(FBPS_REG_CFG, 8'h00, 1'h0);
    repeat (3) @(negedge ref_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset(8'hf8, 8'h83);
    reg_addr = FBPS_REG_PROT;
    #1 chk(16'(reg_rdata), 16'h00f8);
    reg_addr = FBPS_REG_OPT;
    #1 chk(16'(reg_rdata), 16'h0083);
    chk(16'({secured, debug_enable_allow}), 16'h0002);
    mem_req = 1'h1;
    cmd_launch = 1'h1;
    foreach (rows[i]) begin
      mem_addr = rows[i].a;
      {vector_fetch, code_in_secure, from_debug} = rows[i].f;
      cmd_addr = rows[i].c;
      #1 chk(phys_addr, rows[i].ph);
      chk(16'(mem_rdata), 16'(rows[i].rd));
      chk(16'({cmd_discard, cmd_allow}), 16'({rows[i].dis, ~rows[i].dis}));
      @(negedge ref_clk);
    end
    cmd_launch = 1'h0;
    mem_req = 1'h0;
    {vector_fetch, code_in_secure, from_debug} = 3'h2;
    wreg(FBPS_REG_PROT, 8'hff, 1'h0);
    #1 chk(16'(reg_rdata), 16'h00f8);
    wreg(FBPS_REG_PROT, 8'hff, 1'h1);
    #1 chk(16'(reg_rdata), 16'h00ff);
    wreg(FBPS_REG_CFG, 8'h20, 1'h1);
    reg_addr = FBPS_REG_CFG;
    #1 chk(16'(reg_rdata), 16'h0000);
    vector_fetch = 1'h1;
    cmd_launch = 1'h1;
    mem_addr = 16'hffc0;
    cmd_addr = 16'hffff;
    #1 chk(phys_addr, 16'hffc0);
    chk(16'(cmd_discard), 16'h0000);
    @(negedge ref_clk);
    vector_fetch = 1'h0;
    cmd_launch = 1'h0;
    key_try(1'h1, 1'h1);
    chk(16'(secured), 16'h0001);
    key_try(1'h0, 1'h1);
    reg_addr = FBPS_REG_OPT;
    #1 chk(16'({secured, debug_enable_allow, reg_rdata}), 16'h0182);
    for (int s = 0; s < 4; s++) begin
      do_reset(8'hff, 8'h80 | 8'(s));
      chk(16'(secured), 16'(s != 2));
    end
    // option bit 7 low: a correct key must not unlock
    do_reset(8'hff, 8'h03);
    key_try(1'h0, 1'h0);
    chk(16'(secured), 16'h0001);
    {from_debug, cmd_launch, cmd_is_blank_check, blank_ok} = 4'hf;
    @(negedge ref_clk);
    {from_debug, cmd_launch, cmd_is_blank_check, blank_ok} = 4'h0;
    repeat (2) @(negedge ref_clk);
    chk(16'(secured), 16'h0000);
    end_of_test();
  end
endmodule
